//--- hw/ivp_ctrl.sv
// Interrupt gathering, priority choice, stacking and vector fetch, with APB registers.
// Assumes a core that stalls while busy is high and memory that answers one cycle after memRd.
//
// How it works
// (RQ1) Vector is two bytes: high byte at even address, low byte next.
// (RQ2) An event sets its flag regardless of the local enable.
// (RQ3) A source requests only while flag and local enable are both 1.
// (RQ4) Maskable requests are accepted only while the global mask bit is 0.
// (RQ5) Entry starts only once the current instruction has completed; a reset cause starts the vector fetch from idle without waiting for instrDone.
// (RQ6) Stack PC low, PC high, index, accumulator, then condition codes.
// (RQ7) After stacking set the mask, fetch the winning vector, jump there.
// (RQ8) Lower vector number always wins; reset 0 highest, 22 lowest.
// (RQ9) Vector n lives at 0xfffe minus 2n; sources fixed per vector.
// (RQ10) Vectors 23 to 31 have no source and are never selected.
// (RQ11) All reset causes use the single top reset vector.
// (RQ12) A shared vector requests when any of its enabled flags is set.
// (RQ13) Requests stay pending until cleared; priority re-chosen at every entry.
`timescale 1ns/100ps
module ivp_ctrl import ivp_pkg::*; #(
  parameter int NSRC = NUM_SRC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NSRC-1:0] srcEvent,
  input wire ivp_rst_s rstCause,
  input wire logic instrDone,
  input wire logic trapReq,
  input wire ivp_ctx_s ctx,
  input wire logic [7:0] memRdata,
  output logic irqOut,
  output logic busy,
  output ivp_stk_s stk,
  output logic memRd,
  output logic [15:0] memAddr,
  output logic pcLoad,
  output logic [15:0] newPc,
  output logic [15:0] newSp,
  output logic iSet
);
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] clrMask;
  logic [NSRC-1:0] enable_r;
  logic [NSRC-1:0] enable_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic setup;
  logic access;
  logic hit;
  logic [NSRC-1:0] pending;
  logic [NUM_VEC-1:0] hwVecReq;
  logic [NUM_VEC-1:0] encReq;
  logic [VEC_W-1:0] encIdx;
  logic encValid;
  logic rstAny;
  logic hwOk;

  ivp_state_e state_r;
  ivp_state_e state_nxt;
  logic [2:0] step_r;
  logic [2:0] step_nxt;
  ivp_ctx_s ctx_r;
  ivp_ctx_s ctx_nxt;
  logic [VEC_W-1:0] vec_r;
  logic [VEC_W-1:0] vec_nxt;
  logic [VEC_W-1:0] lastVec_r;
  logic [VEC_W-1:0] lastVec_nxt;
  logic trapPend_r;
  logic trapPend_nxt;
  logic hwAcc_r;
  logic hwAcc_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  ivp_stk_s stk_r;
  ivp_stk_s stk_nxt;
  logic memRd_r;
  logic memRd_nxt;
  logic [15:0] memAddr_r;
  logic [15:0] memAddr_nxt;
  logic pcLoad_r;
  logic pcLoad_nxt;
  logic [15:0] newPc_r;
  logic [15:0] newPc_nxt;
  logic [15:0] newSp_r;
  logic [15:0] newSp_nxt;
  logic iSet_r;
  logic iSet_nxt;

  ivp_flag_bank #(
    .N(NSRC)
  ) u_flags (
    .mclk(mclk),
    .rst_n(rst_n),
    .setEv(srcEvent),
    .clrMask(clrMask),
    .flags(flags)
  );

  // Request gathering per vector
  always_comb begin
    pending = flags & enable_r; // [RQ3]
    hwVecReq = '0;
    for (int s = 0; s < NSRC; s++) begin
      if (pending[s]) begin
        hwVecReq[SRC_VEC[s]] = 1'b1; // [RQ9] [RQ10] [RQ12]
      end
    end
  end

  assign irqOut = |pending;
  assign rstAny = |rstCause;
  assign hwOk = irqOut & ~ctx.condCode[MASK_BIT]; // [RQ4]

  // Hardware vectors count only if a qualified request began this entry
  always_comb begin
    encReq = hwVecReq & {NUM_VEC{hwAcc_r}};
    encReq[VEC_TRAP] = trapPend_r;
    encReq[VEC_RESET] = 1'b0;
  end

  ivp_prio_enc #(
    .N(NUM_VEC),
    .W(VEC_W)
  ) u_enc (
    .req(encReq),
    .idx(encIdx),
    .valid(encValid)
  );

  // APB slave, zero wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = (paddr == ADDR_FLAGS) | (paddr == ADDR_ENABLE) | (paddr == ADDR_STATE);
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = prdata_r;

  always_comb begin
    enable_nxt = enable_r;
    prdata_nxt = prdata_r;
    clrMask = '0;
    if (setup && !pwrite) begin
      prdata_nxt = '0;
      unique case (paddr)
        ADDR_FLAGS: prdata_nxt[NSRC-1:0] = flags;
        ADDR_ENABLE: prdata_nxt[NSRC-1:0] = enable_r;
        ADDR_STATE: begin
          prdata_nxt[ST_VEC_LSB +: VEC_W] = lastVec_r;
          prdata_nxt[ST_BUSY_BIT] = busy;
          prdata_nxt[ST_IRQ_BIT] = irqOut;
        end
        default: prdata_nxt = '0;
      endcase
    end
    if (access && pwrite && paddr == ADDR_ENABLE) begin
      enable_nxt = pwdata[NSRC-1:0];
    end
    // Reading clears only the flags returned, so a new event is kept
    if (access && !pwrite && paddr == ADDR_FLAGS) begin
      clrMask = prdata_r[NSRC-1:0]; // [RQ13]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= ENABLE_RST;
      prdata_r <= '0;
    end else begin
      enable_r <= enable_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Entry sequencer
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    ctx_nxt = ctx_r;
    vec_nxt = vec_r;
    lastVec_nxt = lastVec_r;
    trapPend_nxt = trapPend_r;
    hwAcc_nxt = hwAcc_r;
    hi_nxt = hi_r;
    stk_nxt = '0;
    memRd_nxt = 1'b0;
    memAddr_nxt = memAddr_r;
    pcLoad_nxt = 1'b0;
    newPc_nxt = newPc_r;
    newSp_nxt = newSp_r;
    iSet_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (rstAny) begin
          vec_nxt = VEC_RESET; // [RQ11]
          iSet_nxt = 1'b1;
          newSp_nxt = ctx.sp;
          state_nxt = ST_VECHI;
        end else if (instrDone && (trapReq || hwOk)) begin // [RQ5]
          ctx_nxt = ctx;
          trapPend_nxt = trapReq;
          hwAcc_nxt = hwOk;
          step_nxt = '0;
          state_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        stk_nxt.we = 1'b1;
        stk_nxt.addr = ctx_r.sp - 16'(step_r);
        unique case (step_r)
          3'h0: stk_nxt.data = ctx_r.pc[7:0]; // [RQ6]
          3'h1: stk_nxt.data = ctx_r.pc[15:8];
          3'h2: stk_nxt.data = ctx_r.x;
          3'h3: stk_nxt.data = ctx_r.a;
          default: stk_nxt.data = ctx_r.condCode;
        endcase
        step_nxt = step_r + 3'h1;
        if (step_r == 3'(NUM_PUSH - 1)) begin
          iSet_nxt = 1'b1; // [RQ7]
          newSp_nxt = ctx_r.sp - 16'(NUM_PUSH);
          if (encValid) begin
            vec_nxt = encIdx; // [RQ8] [RQ13]
          end else begin
            vec_nxt = VEC_RESET;
          end
          state_nxt = ST_VECHI;
        end
      end
      ST_VECHI: begin
        memRd_nxt = 1'b1;
        memAddr_nxt = VEC_TOP - {10'h000, vec_r, 1'b0}; // [RQ9] [RQ1]
        lastVec_nxt = vec_r;
        trapPend_nxt = 1'b0;
        hwAcc_nxt = 1'b0;
        state_nxt = ST_VECLO;
      end
      ST_VECLO: begin
        memRd_nxt = 1'b1;
        memAddr_nxt = memAddr_r + 16'h0001; // [RQ1]
        state_nxt = ST_CAPHI;
      end
      ST_CAPHI: begin
        hi_nxt = memRdata;
        state_nxt = ST_CAPLO;
      end
      ST_CAPLO: begin
        newPc_nxt = {hi_r, memRdata}; // [RQ1] [RQ7]
        pcLoad_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      step_r <= '0;
      ctx_r <= '0;
      vec_r <= '0;
      lastVec_r <= '0;
      trapPend_r <= 1'b0;
      hwAcc_r <= 1'b0;
      hi_r <= '0;
      stk_r <= '0;
      memRd_r <= 1'b0;
      memAddr_r <= '0;
      pcLoad_r <= 1'b0;
      newPc_r <= '0;
      newSp_r <= '0;
      iSet_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      ctx_r <= ctx_nxt;
      vec_r <= vec_nxt;
      lastVec_r <= lastVec_nxt;
      trapPend_r <= trapPend_nxt;
      hwAcc_r <= hwAcc_nxt;
      hi_r <= hi_nxt;
      stk_r <= stk_nxt;
      memRd_r <= memRd_nxt;
      memAddr_r <= memAddr_nxt;
      pcLoad_r <= pcLoad_nxt;
      newPc_r <= newPc_nxt;
      newSp_r <= newSp_nxt;
      iSet_r <= iSet_nxt;
    end
  end

  assign busy = (state_r != ST_IDLE) | pcLoad_r;
  assign stk = stk_r;
  assign memRd = memRd_r;
  assign memAddr = memAddr_r;
  assign pcLoad = pcLoad_r;
  assign newPc = newPc_r;
  assign newSp = newSp_r;
  assign iSet = iSet_r;
endmodule : ivp_ctrl

//--- include/ivp_pkg.sv
// Shared constants, types and the source-to-vector map of the interrupt block.
// Assumes one clock domain and an APB master with 32-bit data.
package ivp_pkg;
  localparam int NUM_SRC = 28;
  localparam int NUM_VEC = 32;
  localparam int VEC_W = 5;
  localparam int NUM_PUSH = 5;
  localparam int MASK_BIT = 3;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_TRAP = 5'h01;
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [NUM_SRC-1:0] ENABLE_RST = 28'h0;
  localparam int ST_VEC_LSB = 0;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_IRQ_BIT = 9;

  // Vector number of each flag/enable pair; several pairs may share one vector
  localparam logic [4:0] SRC_VEC [0:NUM_SRC-1] = '{
    5'h02, 5'h03, 5'h04,                     // External pin, voltage detect, clock gen
    5'h05, 5'h06, 5'h07,                     // Timer one
    5'h08, 5'h09, 5'h0a,                     // Timer two
    5'h0b, 5'h0b, 5'h0c, 5'h0c,              // SPI one, SPI two
    5'h0d, 5'h0d, 5'h0d, 5'h0d,              // Serial errors
    5'h0e, 5'h0e, 5'h0f, 5'h0f,              // Serial receive, transmit
    5'h10, 5'h11, 5'h12, 5'h13,              // Keyboards, converter, comparator
    5'h14, 5'h15, 5'h16                      // I2C, periodic tick, display
  };

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_VECHI = 3'b010,
    ST_VECLO = 3'b011,
    ST_CAPHI = 3'b100,
    ST_CAPLO = 3'b101
  } ivp_state_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] condCode;
    logic [15:0] sp;
  } ivp_ctx_s;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } ivp_stk_s;

  typedef struct packed {
    logic watchdogTimeout;
    logic clockGenLoss;
    logic lowVoltageDetect;
    logic powerOn;
    logic resetPin;
    logic illegalOp;
  } ivp_rst_s;
endpackage : ivp_pkg

//--- hw/ivp_flag_bank.sv
// Sticky status flags, one per flag/enable pair.
// Assumes set pulses and clear masks synchronous to mclk.
`timescale 1ns/100ps
module ivp_flag_bank #(
  parameter int N = 28
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [N-1:0] setEv,
  input wire logic [N-1:0] clrMask,
  output logic [N-1:0] flags
);
  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  // Set wins over a clear in the same cycle
  always_comb begin
    flags_nxt = (flags_r & ~clrMask) | setEv; // [RQ2] [RQ13]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule : ivp_flag_bank

//--- hw/ivp_prio_enc.sv
// Fixed-priority encoder: the lowest set index wins.
// Assumes a combinational use inside the entry sequencer.
`timescale 1ns/100ps
module ivp_prio_enc #(
  parameter int N = 32,
  parameter int W = 5
) (
  input wire logic [N-1:0] req,
  output logic [W-1:0] idx,
  output logic valid
);
  always_comb begin
    idx = '0;
    valid = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = W'(i); // [RQ8]
        valid = 1'b1;
      end
    end
  end
endmodule : ivp_prio_enc

//--- sim/ivp_sva.sv
// Port checks on the interrupt block's entry sequence.
// Assumes one clock domain; bound to the top module by name.
`timescale 1ns/100ps
module ivp_sva import ivp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire ivp_rst_s rstCause,
  input wire logic instrDone,
  input wire logic trapReq,
  input wire ivp_ctx_s ctx,
  input wire logic irqOut,
  input wire logic busy,
  input wire ivp_stk_s stk,
  input wire logic memRd,
  input wire logic [15:0] memAddr,
  input wire logic pcLoad,
  input wire logic [15:0] newSp,
  input wire logic iSet
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic idle;
  assign idle = !busy && instrDone && !(|rstCause);
  sequence s_push;
    stk.we [*5] ##1 !stk.we;
  endsequence
  sequence s_frame;
    stk.data == $past(ctx.pc[7:0], 2) ##1 stk.data == $past(ctx.pc[15:8], 3)
    ##1 stk.data == $past(ctx.x, 4) ##1 stk.data == $past(ctx.a, 5)
    ##1 stk.data == $past(ctx.condCode, 6);
  endsequence
  sequence s_fetch(logic [15:0] a);
    memRd && memAddr == a ##1 memRd && memAddr == a + 16'h1;
  endsequence
  property p_mask;
    idle && !trapReq && irqOut && ctx.condCode[MASK_BIT] |=> !busy;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request taken");
  property p_wait;
    !busy && !instrDone && !(|rstCause) |=> !busy;
  endproperty
  a_wait: assert property (p_wait) else $error("entry before boundary");
  property p_push;
    $rose(stk.we) |-> s_push;
  endproperty
  a_push: assert property (p_push) else $error("stack burst length");
  property p_frame;
    $rose(stk.we) |-> s_frame;
  endproperty
  a_frame: assert property (p_frame) else $error("stack byte order");
  property p_order;
    stk.we && $past(stk.we) |-> stk.addr == $past(stk.addr) - 16'h1;
  endproperty
  a_order: assert property (p_order) else $error("stack address order");
  property p_iset;
    $rose(stk.we) |-> ##4 (iSet && stk.we && newSp == stk.addr - 16'h1);
  endproperty
  a_iset: assert property (p_iset) else $error("mask or stack pointer");
  property p_fetch;
    $rose(memRd) |-> !memAddr[0] && memAddr >= 16'hffd2 ##1 memRd ##1 !memRd;
  endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch pair");
  property p_load;
    $rose(memRd) |-> ##3 pcLoad;
  endproperty
  a_load: assert property (p_load) else $error("jump timing");
  property p_rst;
    (|rstCause) && !busy |-> ##[2:4] s_fetch(VEC_TOP);
  endproperty
  a_rst: assert property (p_rst) else $error("reset vector");
  property p_trap;
    idle && trapReq |-> ##[6:8] s_fetch(16'hfffc);
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector");
endmodule : ivp_sva

//--- sim/ivp_mem_model.sv
// Memory partner that answers vector byte reads.
// Assumes read strobes from the block on mclk.
`timescale 1ns/100ps
module ivp_mem_model (
  input wire logic mclk,
  input wire logic memRd,
  input wire logic [15:0] memAddr,
  output logic [7:0] memRdata
);
  logic [7:0] data_r = 8'h00;
  // Byte one cycle after a read, a changing pattern otherwise
  always @(posedge mclk) begin
    data_r <= memRd ? ~memAddr[7:0] : ~data_r;
  end
  assign memRdata = data_r;
endmodule : ivp_mem_model

//--- sim/tb_top.sv
// Self-checking bench for the interrupt block and its memory partner.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
module tb_top import ivp_pkg::*;;
  logic mclk = 0;
  logic rst_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, instrDone = 0, trapReq = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irqOut, busy, memRd, pcLoad, iSet;
  logic [NUM_SRC-1:0] srcEvent = '0, m;
  ivp_rst_s rstCause = '0;
  ivp_ctx_s ctx = '0;
  logic [7:0] memRdata;
  ivp_stk_s stk;
  logic [15:0] memAddr, newPc, newSp;
  integer seed = 22;
  int n_mismatch = 0, checks_done = 0, a, b;
  logic [4:0] v;
  logic [15:0] qp[$];
  logic [32:0] qr[$];
  ivp_ctrl dut_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .srcEvent(srcEvent),
    .rstCause(rstCause),
    .instrDone(instrDone),
    .trapReq(trapReq),
    .ctx(ctx),
    .memRdata(memRdata),
    .irqOut(irqOut),
    .busy(busy),
    .stk(stk),
    .memRd(memRd),
    .memAddr(memAddr),
    .pcLoad(pcLoad),
    .newPc(newPc),
    .newSp(newSp),
    .iSet(iSet)
  );
  ivp_mem_model mem_u (
    .mclk(mclk),
    .memRd(memRd),
    .memAddr(memAddr),
    .memRdata(memRdata)
  );
  initial forever #20 mclk = ~mclk;
  function automatic logic [15:0] vpc(input int n);
    logic [7:0] x;
    x = 8'hfe - 8'(2 * n);
    return {~x, ~(x + 8'h1)};
  endfunction : vpc
  task automatic cmp_pc(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH newPc exp %h got %h", e, g);
    end
  endtask : cmp_pc
  task automatic cmp_rd(input logic [32:0] g);
    logic [32:0] e;
    e = qr.size() ? qr.pop_front() : 'x;
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH prdata exp %h got %h", e, g);
    end
  endtask : cmp_rd
  always @(posedge mclk) begin
    if (pcLoad === 1'b1) cmp_pc(qp.size() ? qp.pop_front() : 16'hx, newPc);
    if (psel && penable && !pwrite && pready) cmp_rd({pslverr, prdata});
  end
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [32:0] e);
    qr.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask : rd
  task automatic ev(input logic [NUM_SRC-1:0] e);
    srcEvent <= e;
    @(posedge mclk);
    srcEvent <= '0;
    @(posedge mclk);
  endtask : ev
  task automatic ent(input logic sw, input logic mk, input ivp_rst_s rc, input int n);
    ivp_ctx_s c;
    c = ivp_ctx_s'(56'({$random(seed), $random(seed)}));
    c.condCode[MASK_BIT] = mk;
    if (n >= 0) qp.push_back(vpc(n));
    ctx <= c;
    instrDone <= 1'b1;
    trapReq <= sw;
    rstCause <= rc;
    @(posedge mclk);
    instrDone <= 1'b0;
    trapReq <= 1'b0;
    rstCause <= '0;
    repeat (14) @(posedge mclk);
  endtask : ent
  task automatic test_done;
    n_mismatch += qp.size() + qr.size();
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(ADDR_ENABLE, 33'h0);
    rd(8'h0c, 33'h1_0000_0000);
    for (int i = 0; i < NUM_SRC; i++) begin
      ev(NUM_SRC'(1) << i);
      rd(ADDR_STATE, 33'h0);
      rd(ADDR_FLAGS, 33'(1) << i);
    end
    r = $random(seed);
    apb(1'b1, ADDR_ENABLE, r);
    rd(ADDR_ENABLE, {5'h0, r[27:0]});
    apb(1'b1, ADDR_ENABLE, 32'hffff_ffff);
    for (int k = 0; k < 12; k++) begin
      a = {$random(seed)} % NUM_SRC;
      b = {$random(seed)} % NUM_SRC;
      m = (NUM_SRC'(1) << a) | (NUM_SRC'(1) << b);
      v = (SRC_VEC[a] < SRC_VEC[b]) ? SRC_VEC[a] : SRC_VEC[b];
      ev(m);
      ent(1'b0, 1'b1, '0, -1);
      ent(1'b0, 1'b0, '0, v);
      ent(1'b1, 1'b0, '0, 1);
      rd(ADDR_STATE, 33'h201);
      rd(ADDR_FLAGS, 33'(m));
    end
    for (int i = 0; i < 6; i++) ent(1'b0, 1'b1, ivp_rst_s'(6'(1) << i), 0);
    test_done;
  end
endmodule : tb_top
bind ivp_ctrl ivp_sva chk_u (
  .mclk(mclk),
  .rst_n(rst_n),
  .rstCause(rstCause),
  .instrDone(instrDone),
  .trapReq(trapReq),
  .ctx(ctx),
  .irqOut(irqOut),
  .busy(busy),
  .stk(stk),
  .memRd(memRd),
  .memAddr(memAddr),
  .pcLoad(pcLoad),
  .newSp(newSp),
  .iSet(iSet)
);
